// >>> rtl/scs_consts.svh
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// System clock period and the power-on reset hold time
`define SCS_CLK_NS 10
`define SCS_POR_NS 2000
`define SCS_POR_CYCLES ((`SCS_POR_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

// Serial clocks issued after the master's select goes high at the end
`define SCS_TRAIL_CLKS 16

// System clocks per half period of the generated serial clock
`define SCS_DIV_HALF 4

// Address width for a 2-megabit array, one bit per address
`define SCS_ADDR_W 21

// Polarity value: 1 means reset active low, enable active high
`define SCS_POL_RST_LOW 1'b1

// Reset values of the synchronised inputs {toggle, prog_n, cs_n, oe}
`define SCS_SYNC_RST_VAL 4'h6

`endif

// >>> rtl/scs_pkg.sv
package scs_pkg;

    // Gray-coded along POR -> WAIT -> RUN -> TRAIL -> SLEEP
    typedef enum logic [2:0] {
        SCS_POR = 3'h0,
        SCS_WAIT = 3'h1,
        SCS_RUN = 3'h3,
        SCS_TRAIL = 3'h2,
        SCS_SLEEP = 3'h6
    } scs_mode_t;

    // Pin drive bundle; each *_oe is high while the device drives the pin
    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic sclk_o;
        logic sclk_oe;
        logic cascade_select_n;
        logic ready_o;
        logic ready_oe;
    } scs_pins_t;

endpackage

// >>> rtl/scs_sync.sv
`timescale 1ns/100ps

module scs_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import scs_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } scs_sync_st_t;

    scs_sync_st_t st_reg;
    scs_sync_st_t st_next;

    // First stage feeds only the second stage
    always_comb begin
        st_next = st_reg;
        st_next.meta = d;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '{meta: RST_VAL, stable: RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.stable;

endmodule

// >>> rtl/scs_stream_source.sv
// Function
// - Reset level clears counter, floats data
// - Select high after reset: halted, floated
// - Select low after reset: count and drive
// - New reset wins over chip select
// - All bits out, cascade low: float data
// - Power-up clears counter without external reset
// - Ready held low during power-on reset
// - Master shifts bits out on own oscillator; follower on received clock
// - Select level at reset picks master/follower
// - Master clocks everyone until configuration complete
// - Last bit sent: drive cascade select low
// - Master adds 16 clocks then sleeps
// - Reset input polarity from stored setting
// - Rising edge advances only when enabled
// - Cascade low on the advance at maximum address
// - Reset stops oscillator, clock pin low
`timescale 1ns/100ps
`include "scs_consts.svh"

module scs_stream_source #(
    parameter int ADDR_W = `SCS_ADDR_W,
    parameter int DIV_HALF = `SCS_DIV_HALF,
    parameter int POR_CYCLES = `SCS_POR_CYCLES,
    parameter int TRAIL_CLKS = `SCS_TRAIL_CLKS,
    parameter logic DEF_POL = `SCS_POL_RST_LOW
) (
    // System clock and power-up reset
    input wire logic clk,
    input wire logic rst,
    // Serial clock as seen on the pin, used when following
    input wire logic link_clk,
    // Control pins from the host
    input wire logic oe_rst_pin,
    input wire logic chip_select_n,
    input wire logic program_mode_select_n,
    // Nonvolatile store load port, system clock domain
    input wire logic prog_we,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic prog_bit,
    input wire logic prog_pol_we,
    input wire logic prog_pol,
    // Pin drive and status
    output scs_pkg::scs_pins_t pins,
    output logic master_role,
    output scs_pkg::scs_mode_t mode,
    output logic [ADDR_W-1:0] read_addr
);
    import scs_pkg::*;

    // Counter widths carry one spare bit so the compares never wrap
    localparam int DIV_W = $clog2(DIV_HALF + 1) + 1;
    localparam int POR_W = $clog2(POR_CYCLES + 1) + 1;
    localparam int TRL_W = $clog2(TRAIL_CLKS + 1) + 1;
    localparam logic [ADDR_W-1:0] ADDR_MAX = '1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_HALF - 1);
    localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);
    localparam logic [TRL_W-1:0] TRL_FULL = TRL_W'(TRAIL_CLKS);

    typedef struct packed {
        scs_mode_t mode;
        logic pol;
        logic master;
        logic done;
        logic tog_prev;
        logic [ADDR_W-1:0] addr;
        logic [DIV_W-1:0] div;
        logic [POR_W-1:0] por_cnt;
        logic [TRL_W-1:0] trl_cnt;
        scs_pins_t pins;
    } scs_state_t;

    scs_state_t st_reg;
    scs_state_t st_next;

    // Stored configuration bits; the whole array, one bit per address
    logic mem [0:(1 << ADDR_W) - 1];

    // Link-domain toggle: one flip per rising serial clock edge
    logic link_tog_reg;

    logic [3:0] sync_q;
    logic oe_s;
    logic cs_n_s;
    logic prog_n_s;
    logic tog_s;

    // Reset level of the control input under the stored polarity
    function automatic logic reset_level(input logic pol, input logic lvl);
        reset_level = pol ? ~lvl : lvl;
    endfunction

    // Load port only; the stream reads the array at the next address into
    // the data pin register, so a freshly written bit shows from the next cycle
    always_ff @(posedge clk) begin
        if (prog_we) begin
            mem[prog_addr] <= prog_bit;
        end
    end

    // Follower counts edges of a clock it does not own; the toggle
    // carries each edge into the system domain without losing any,
    // provided rising edges stay at least two system clocks apart;
    // a faster link clock would merge edges and skip bits
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            link_tog_reg <= 1'b0;
        end else begin
            link_tog_reg <= ~link_tog_reg;
        end
    end

    // Pins and the link toggle pass both stages before any logic
    scs_sync #(
        .W(4),
        .RST_VAL(`SCS_SYNC_RST_VAL)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({link_tog_reg, program_mode_select_n, chip_select_n, oe_rst_pin}),
        .q(sync_q)
    );

    assign oe_s = sync_q[0];
    assign cs_n_s = sync_q[1];
    assign prog_n_s = sync_q[2];
    assign tog_s = sync_q[3];

    always_comb begin
        logic halt;
        logic rising;
        logic adv;
        logic clk_run;
        logic falling;
        halt = 1'b0;
        rising = 1'b0;
        adv = 1'b0;
        clk_run = 1'b0;
        falling = 1'b0;
        st_next = st_reg;
        // Last toggle level; a difference marks one received clock edge
        st_next.tog_prev = tog_s;
        if (prog_pol_we) begin
            st_next.pol = prog_pol;
        end
        // Programming mode (select low) also halts reading
        halt = reset_level(st_reg.pol, oe_s) | ~prog_n_s;

        // Every halt outside POR drops back to WAIT with a cleared counter; the select
        // level seen while halted decides the role once the halt ends
        case (st_reg.mode)
            SCS_POR: begin
                // Counter and role settle while the power-on timer runs
                st_next.addr = '0;
                st_next.done = 1'b0;
                st_next.master = ~cs_n_s;
                st_next.por_cnt = st_reg.por_cnt + POR_W'(1);
                if (st_reg.por_cnt == POR_LAST) begin
                    st_next.mode = SCS_WAIT;
                end
            end
            SCS_WAIT: begin
                if (halt) begin
                    st_next.addr = '0;
                    st_next.done = 1'b0;
                    st_next.master = ~cs_n_s;
                end else if (!cs_n_s) begin
                    st_next.mode = SCS_RUN;
                end
                // Select high after reset: stays here, halted
            end
            SCS_RUN: begin
                if (halt) begin
                    st_next.mode = SCS_WAIT;
                    st_next.addr = '0;
                    st_next.done = 1'b0;
                    st_next.master = ~cs_n_s;
                end else if (cs_n_s) begin
                    // Master whose data is all out gets its trailing
                    // clocks; an early raise just halts the counter
                    if (st_reg.master && st_reg.done) begin
                        st_next.mode = SCS_TRAIL;
                        st_next.trl_cnt = '0;
                    end else begin
                        st_next.mode = SCS_WAIT;
                    end
                end else begin
                    clk_run = st_reg.master;
                end
            end
            SCS_TRAIL: begin
                if (halt) begin
                    st_next.mode = SCS_WAIT;
                    st_next.addr = '0;
                    st_next.done = 1'b0;
                    st_next.master = ~cs_n_s;
                end else begin
                    clk_run = 1'b1;
                end
            end
            SCS_SLEEP: begin
                // Zero-power idle until the next reset
                if (halt) begin
                    st_next.mode = SCS_WAIT;
                    st_next.addr = '0;
                    st_next.done = 1'b0;
                    st_next.master = ~cs_n_s;
                end
            end
            default: begin
                st_next.mode = SCS_WAIT;
            end
        endcase

        // Serial clock generator; held low whenever it is not running
        if (clk_run) begin
            if (st_reg.div == DIV_LAST) begin
                st_next.div = '0;
                st_next.pins.sclk_o = ~st_reg.pins.sclk_o;
                rising = ~st_reg.pins.sclk_o;
                falling = st_reg.pins.sclk_o;
            end else begin
                st_next.div = st_reg.div + DIV_W'(1);
            end
        end else begin
            st_next.div = '0;
            st_next.pins.sclk_o = 1'b0;
        end

        // Trailing pulses are counted on their rising edge, but sleep
        // waits for the falling edge after the last one; leaving on the
        // last rise would swallow that pulse and short the host by one
        if (st_reg.mode == SCS_TRAIL && rising) begin
            st_next.trl_cnt = st_reg.trl_cnt + TRL_W'(1);
        end
        if (st_reg.mode == SCS_TRAIL && falling
            && st_reg.trl_cnt == TRL_FULL) begin
            st_next.mode = SCS_SLEEP;
        end

        // Master uses its own edges; a follower the edges it receives
        if (st_reg.mode == SCS_RUN && !halt && !cs_n_s) begin
            if (st_reg.master) begin
                adv = rising;
            end else begin
                adv = tog_s ^ st_reg.tog_prev;
            end
        end

        // Done latches instead of wrapping, so a finished device stays
        // quiet until the next halt
        if (adv && !st_reg.done) begin
            if (st_reg.addr == ADDR_MAX) begin
                st_next.done = 1'b1;
            end else begin
                st_next.addr = st_reg.addr + ADDR_W'(1);
            end
        end

        // Pins follow the next state, so each step and its bit land together
        st_next.pins.cascade_select_n = ~st_next.done;
        st_next.pins.data_o = mem[st_next.addr];
        st_next.pins.data_oe = (st_next.mode == SCS_RUN)
            && !st_next.done;
        // Master drives the clock pin, low while reset
        st_next.pins.sclk_oe = st_next.master;
        // Open-drain ready: the level is always low, only the enable moves
        st_next.pins.ready_o = 1'b0;
        st_next.pins.ready_oe = (st_next.mode == SCS_POR);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // Pins floated, ready held low, cascade inactive
            st_reg.mode <= SCS_POR;
            st_reg.pol <= DEF_POL;
            st_reg.master <= 1'b0;
            st_reg.done <= 1'b0;
            st_reg.tog_prev <= 1'b0;
            st_reg.addr <= '0;
            st_reg.div <= '0;
            st_reg.por_cnt <= '0;
            st_reg.trl_cnt <= '0;
            st_reg.pins <= '{data_o: 1'b0, data_oe: 1'b0, sclk_o: 1'b0,
                             sclk_oe: 1'b0, cascade_select_n: 1'b1,
                             ready_o: 1'b0, ready_oe: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins = st_reg.pins;
    assign master_role = st_reg.master;
    assign mode = st_reg.mode;
    assign read_addr = st_reg.addr;

endmodule

// >>> testbench/scs_stream_checker.sv
`timescale 1ns/100ps
module scs_stream_checker
    import scs_pkg::*;
#(
    parameter int ADDR_W = 21
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic oe_rst_pin,
    input wire logic prog_pol_we,
    input wire logic prog_pol,
    input wire scs_pkg::scs_pins_t pins,
    input wire logic master_role,
    input wire scs_pkg::scs_mode_t mode,
    input wire logic [ADDR_W-1:0] read_addr
);
    logic pol_reg, sclk_reg, lvl;
    logic [4:0] trail_reg;
    // Mirror of the stored polarity, so the reset level is known here
    assign lvl = oe_rst_pin != pol_reg;
    always_ff @(posedge clk) begin
        sclk_reg <= pins.sclk_o;
        pol_reg <= rst ? 1'b1 : (prog_pol_we ? prog_pol : pol_reg);
        trail_reg <= mode != SCS_TRAIL ? 5'h00 :
            trail_reg + {4'h0, pins.sclk_o & ~sclk_reg};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_por_start: assert property ($fell(rst) |-> read_addr == '0)
        else $error("counter not cleared at power-up");
    a_ready_low: assert property (mode == SCS_POR |-> pins.ready_oe)
        else $error("ready not held low");
    a_ready_free: assert property (mode != SCS_POR |-> !pins.ready_oe)
        else $error("ready not released");
    a_oe_reset: assert property (lvl [*5] |->
        read_addr == '0 && !pins.data_oe && !pins.sclk_o)
        else $error("reset level ignored");
    a_wait_halt: assert property (
        mode == SCS_WAIT ##1 mode == SCS_WAIT |->
        $stable(read_addr) || read_addr == '0)
        else $error("counter moved while halted");
    a_run_drive: assert property (
        mode == SCS_RUN && pins.cascade_select_n && !lvl |-> pins.data_oe)
        else $error("data not driven while running");
    a_casc_float: assert property (
        !pins.cascade_select_n |-> !pins.data_oe)
        else $error("data driven after last bit");
    a_addr_step: assert property (
        master_role && mode == SCS_RUN && !lvl && $changed(read_addr) |->
        $rose(pins.sclk_o) && read_addr == $past(read_addr) + 1'b1)
        else $error("address moved off a rising clock");
    a_sleep_quiet: assert property (mode == SCS_SLEEP |-> !pins.sclk_o)
        else $error("clock running in sleep");
    a_trail_count: assert property (
        mode == SCS_TRAIL ##1 mode == SCS_SLEEP |-> trail_reg == 5'h10)
        else $error("wrong count of trailing clocks");
    a_clk_owner: assert property (
        mode == SCS_RUN |-> pins.sclk_oe == master_role)
        else $error("clock driven by wrong role");
endmodule

bind scs_stream_source scs_stream_checker #(.ADDR_W(ADDR_W)) chk_u (
    .clk, .rst, .oe_rst_pin, .prog_pol_we, .prog_pol, .pins,
    .master_role, .mode, .read_addr);

// >>> testbench/scs_fpga_model.sv
`timescale 1ns/100ps
module scs_fpga_model
    import scs_pkg::*;
#(
    parameter int NBITS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration pins
    input wire scs_pkg::scs_pins_t pins,
    output logic config_complete,
    output logic [NBITS-1:0] rx_bits
);
    logic sclk_q, data_q, line, rise;
    int cnt;
    // A floated data line shows a level that changes every cycle
    assign line = pins.data_oe ? pins.data_o : ~data_q;
    assign rise = pins.sclk_o && pins.sclk_oe && !sclk_q;
    always_ff @(posedge clk) begin
        sclk_q <= pins.sclk_o & pins.sclk_oe;
        data_q <= line;
        // Host held in reset while ready is low; not a supply-good delay
        if (rst || pins.ready_oe) begin
            cnt <= 0;
            rx_bits <= '0;
        end else if (rise && cnt < NBITS) begin
            // Bit taken as it stood just before the rising clock
            rx_bits[cnt] <= data_q;
            cnt <= cnt + 1;
        end
        config_complete <= !rst && cnt == NBITS;
    end
endmodule

// >>> testbench/serial_config_stream_source_tb.sv
`timescale 1ns/100ps
module serial_config_stream_source_tb;
    import scs_pkg::*;
    localparam int AW = 4;
    localparam int NB = 16;
    logic clk, rst, link_clk, oe_rst_pin, cs_n_tb, prog_n, done;
    logic prog_we, prog_bit, prog_pol_we, prog_pol, master_role;
    logic [AW-1:0] prog_addr, read_addr;
    logic [NB-1:0] mem_exp, rx_bits;
    scs_pins_t pins;
    scs_mode_t mode;
    int mismatches, compares, k;

    scs_stream_source #(.ADDR_W(AW), .POR_CYCLES(4)) dut_u (
        .clk, .rst, .link_clk, .oe_rst_pin,
        .chip_select_n(cs_n_tb | done), .program_mode_select_n(prog_n),
        .prog_we, .prog_addr, .prog_bit, .prog_pol_we, .prog_pol,
        .pins, .master_role, .mode, .read_addr);
    scs_fpga_model #(.NBITS(NB)) fpga_u (
        .clk, .rst, .pins, .config_complete(done), .rx_bits);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Role a device takes from its select level as reset ends
    function automatic logic exp_master(input logic cs_n);
        return !cs_n;
    endfunction

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_mode(input scs_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            mismatches++;
            conclude();
        end
    endtask

    // Store is loaded while the reset level still holds the counter
    task automatic reset_dut(input logic cs);
        @(posedge clk);
        rst <= 1'b1;
        oe_rst_pin <= 1'b0;
        cs_n_tb <= cs;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk(pins.ready_oe, 1);
        chk(pins.ready_o, 0);
        chk(read_addr, 0);
        settle(7);
        for (int i = 0; i < NB; i++) begin
            @(posedge clk);
            prog_we <= 1'b1;
            prog_addr <= i[AW-1:0];
            prog_bit <= mem_exp[i];
        end
        @(posedge clk);
        prog_we <= 1'b0;
        settle(1);
    endtask

    initial begin
        mismatches = 0;
        compares = 0;
        rst = 1'b1;
        link_clk = 1'b0;
        oe_rst_pin = 1'b0;
        cs_n_tb = 1'b1;
        prog_n = 1'b1;
        prog_we = 1'b0;
        prog_bit = 1'b0;
        prog_addr = '0;
        prog_pol_we = 1'b0;
        prog_pol = 1'b1;
        void'($urandom(32'hA07D3644));
        mem_exp = (NB'($urandom) | 16'h0001) & 16'h7FFF;
        reset_dut(1'b1);
        chk(master_role, exp_master(1'b1));
        chk(pins.ready_oe, 0);
        @(posedge clk);
        oe_rst_pin <= 1'b1;
        settle(6);
        chk(read_addr, 0);
        chk(pins.data_oe, 0);
        @(posedge clk);
        cs_n_tb <= 1'b0;
        wait_mode(SCS_RUN);
        chk(pins.data_oe, 1);
        k = $urandom_range(5, 1);
        // 80 ns link clock, offset from the system clock edges
        #3;
        repeat (k) begin
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        settle(6);
        chk(read_addr, k);
        chk(pins.data_o, mem_exp[k]);
        @(posedge clk);
        oe_rst_pin <= 1'b0;
        settle(6);
        chk(read_addr, 0);
        chk(pins.data_oe, 0);
        reset_dut(1'b0);
        chk(master_role, exp_master(1'b0));
        @(posedge clk);
        oe_rst_pin <= 1'b1;
        wait_mode(SCS_RUN);
        chk(pins.data_o, mem_exp[0]);
        wait_mode(SCS_TRAIL);
        chk(pins.cascade_select_n, 0);
        wait_mode(SCS_SLEEP);
        chk(rx_bits, mem_exp);
        chk(pins.data_oe, 0);
        reset_dut(1'b0);
        @(posedge clk);
        oe_rst_pin <= 1'b1;
        wait_mode(SCS_RUN);
        repeat ($urandom_range(60, 10)) @(posedge clk);
        prog_pol <= 1'b0;
        prog_pol_we <= 1'b1;
        @(posedge clk);
        prog_pol_we <= 1'b0;
        settle(6);
        chk(read_addr, 0);
        chk(pins.sclk_o, 0);
        @(posedge clk);
        oe_rst_pin <= 1'b0;
        wait_mode(SCS_RUN);
        chk(pins.data_oe, 1);
        conclude();
    end
endmodule
